// file: fcm_core_model.sv
`timescale 1ns/1ps
// Stand-in for the arithmetic core: answers after a delay set by the bench
module fcm_core_model (
	input wire logic i_clk_sys,
	input wire logic i_req,
	input wire logic [8:0] i_op,
	input wire logic [127:0] i_a,
	input wire logic [127:0] i_b,
	input wire logic [3:0] i_dly,
	input wire logic [3:0] i_flg,
	output logic o_done = 1'b0,
	output logic [127:0] o_res = '0,
	output logic [3:0] o_flags = '0
);
	import fcm_pkg::*;
	int cnt = -1;
	// Result lines scramble outside the answer cycle, so stale data is never trusted
	always @(posedge i_clk_sys) begin
		if (i_req) cnt = i_dly;
		else if (cnt > 0) cnt = cnt - 1;
		if (cnt == 0) begin
			o_done <= 1'b1;
			o_flags <= i_flg;
			// Sum, difference, or a plain pattern for single-operand ops
			o_res <= i_op[8:2] == OPF_ADD_S[8:2] ? i_a + i_b : i_op[8:2] == OPF_SUB_S[8:2] ? i_a - i_b : ~i_b;
			cnt = -1;
		end else begin
			o_done <= 1'b0;
			o_res <= ~o_res;
			o_flags <= ~o_flags;
		end
	end
endmodule

// file: fcm_pkg.sv
package fcm_pkg;
	// Instruction word fields
	localparam logic [1:0] FMT3 = 2'h2;
	localparam logic [5:0] OP3_GROUP_ONE = 6'h34;
	// Operation-select codes
	localparam logic [8:0] OPF_MOV = 9'h001;
	localparam logic [8:0] OPF_NEG = 9'h005;
	localparam logic [8:0] OPF_ABS = 9'h009;
	localparam logic [8:0] OPF_S2D = 9'h0C9;
	localparam logic [8:0] OPF_S2Q = 9'h0CD;
	localparam logic [8:0] OPF_D2S = 9'h0C6;
	localparam logic [8:0] OPF_D2Q = 9'h0CE;
	localparam logic [8:0] OPF_Q2S = 9'h0C7;
	localparam logic [8:0] OPF_Q2D = 9'h0CB;
	localparam logic [8:0] OPF_SQRT_S = 9'h029;
	localparam logic [8:0] OPF_SQRT_D = 9'h02A;
	localparam logic [8:0] OPF_SQRT_Q = 9'h02B;
	localparam logic [8:0] OPF_ADD_S = 9'h041;
	localparam logic [8:0] OPF_ADD_D = 9'h042;
	localparam logic [8:0] OPF_ADD_Q = 9'h043;
	localparam logic [8:0] OPF_SUB_S = 9'h045;
	localparam logic [8:0] OPF_SUB_D = 9'h046;
	localparam logic [8:0] OPF_SUB_Q = 9'h047;
	// Precision codes, ordered so wider compares greater
	localparam logic [1:0] P_S = 2'h1;
	localparam logic [1:0] P_D = 2'h2;
	localparam logic [1:0] P_Q = 2'h3;
	// Exception flag positions
	localparam int F_OVERFLOW = 3;
	localparam int F_UNDERFLOW = 2;
	localparam int F_INEXACT = 1;
	localparam int F_BAD_OP = 0;
	// Register port map
	localparam int NREG = 32;
	localparam logic [5:0] ADDR_STATUS = 6'h20;
	localparam int ST_BUSY = 4;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_WAIT = 2'b10
	} fcm_state_e;
	typedef enum logic [2:0] {
		C_BAD, C_MOV, C_NEG, C_ABS, C_CVT, C_SQRT, C_ADD, C_SUB
	} fcm_class_e;
endpackage

// file: fcm_unit.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - Decode group-one operates, select by opf.
// - Disabled or absent unit takes off trap.
// - Misaligned double/quad register raises fault.
// - Conversions read source B, write destination.
// - Decode single-to-double and single-to-quad.
// - Decode double-to-single and double-to-quad.
// - Decode quad-to-single and quad-to-double.
// - Conversions round per rounding-direction field.
// - Narrowing conversions may flag overflow, underflow, inexact.
// - Widening conversions never flag overflow, underflow, inexact.
// - Conversion of signaling NaN raises invalid.
// - Word copy moves source unchanged.
// - Sign flip inverts sign bit.
// - Sign clear forces sign bit zero.
// - Moves never round nor raise exceptions.
// - Square root three precisions, invalid/inexact only.
// - Add writes source A plus source B.
// - Subtract writes A minus B, may flag.
module fcm_unit (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_valid,
	input wire logic [31:0] i_instr,
	input wire logic i_fpu_enable_bit,
	input wire logic i_fpu_present,
	input wire logic [1:0] i_round_dir,
	input wire logic [3:0] i_trap_mask,
	input wire logic i_ar_done,
	input wire logic [127:0] i_ar_result,
	input wire logic [3:0] i_ar_flags,
	input wire logic [5:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic o_busy,
	output logic o_done,
	output logic [3:0] o_flags,
	output logic o_fpu_off_trap,
	output logic o_fpu_fault_trap,
	output logic o_misaligned_fpreg_fault,
	output logic o_unimpl_fault,
	output logic o_ar_req,
	output logic [8:0] o_ar_op,
	output logic [127:0] o_ar_a,
	output logic [127:0] o_ar_b,
	output logic [1:0] o_ar_round
);
	import fcm_pkg::*;
	logic [31:0] fr_q [NREG];
	logic [31:0] fr_d [NREG];
	fcm_state_e st_q, st_d;
	fcm_class_e cls, cls_q, cls_d;
	logic [1:0] sp, dp, sp_q, sp_d, dp_q, dp_d;
	logic [4:0] rd_q, rd_d;
	logic snan_q, snan_d;
	logic [3:0] flags_q, flags_d, acc_q, acc_d, fnew;
	logic done_q, done_d, off_q, off_d, fault_q, fault_d;
	logic mis_q, mis_d, unimpl_q, unimpl_d;
	logic req_q, req_d;
	logic [8:0] op_q, op_d;
	logic [127:0] a_q, a_d, b_q, b_d, wres;
	logic [1:0] rnd_q, rnd_d;
	logic [31:0] rdata_q, rdata_d, mv;
	logic ours, take, misal, dyadic;
	logic [8:0] opf;
	logic [4:0] rd, src_a, src_b;
	// Aligned base of a register group; low bits are ignored, not trusted
	function automatic logic [4:0] base(input logic [4:0] r, input logic [1:0] p);
		base = (p == P_Q) ? {r[4:2], 2'h0} : (p == P_D) ? {r[4:1], 1'h0} : r;
	endfunction
	function automatic logic bad_align(input logic [4:0] r, input logic [1:0] p);
		bad_align = ((p == P_D) && r[0]) || ((p == P_Q) && (r[1:0] != 2'h0));
	endfunction
	// Operand right-aligned, most significant word from the lowest register
	function automatic logic [127:0] rd_op(input logic [4:0] r, input logic [1:0] p);
		logic [4:0] b;
		b = base(r, p);
		case (p)
			P_D: rd_op = {64'h0, fr_q[b], fr_q[b + 5'h1]};
			P_Q: rd_op = {fr_q[b], fr_q[b + 5'h1], fr_q[b + 5'h2], fr_q[b + 5'h3]};
			default: rd_op = {96'h0, fr_q[r]};
		endcase
	endfunction
	// Signaling NaN: exponent all ones, quiet bit clear, fraction nonzero
	function automatic logic is_snan(input logic [127:0] v, input logic [1:0] p);
		case (p)
			P_D: is_snan = (&v[62:52]) && !v[51] && (v[50:0] != 51'h0);
			P_Q: is_snan = (&v[126:112]) && !v[111] && (v[110:0] != 111'h0);
			default: is_snan = (&v[30:23]) && !v[22] && (v[21:0] != 22'h0);
		endcase
	endfunction
	// Instruction fields and operation decode
	always_comb begin
		opf = i_instr[13:5];
		rd = i_instr[29:25];
		src_a = i_instr[18:14];
		src_b = i_instr[4:0];
		ours = (i_instr[31:30] == FMT3) && (i_instr[24:19] == OP3_GROUP_ONE);
		sp = opf[1:0];
		dp = opf[1:0];
		case (opf)
			OPF_MOV: cls = C_MOV;
			OPF_NEG: cls = C_NEG;
			OPF_ABS: cls = C_ABS;
			OPF_S2D, OPF_S2Q: cls = C_CVT;
			OPF_D2S, OPF_D2Q: cls = C_CVT;
			OPF_Q2S, OPF_Q2D: cls = C_CVT;
			OPF_SQRT_S, OPF_SQRT_D, OPF_SQRT_Q: cls = C_SQRT;
			OPF_ADD_S, OPF_ADD_D, OPF_ADD_Q: cls = C_ADD;
			OPF_SUB_S, OPF_SUB_D, OPF_SUB_Q: cls = C_SUB;
			default: cls = C_BAD;
		endcase
		if (cls == C_MOV || cls == C_NEG || cls == C_ABS) begin
			sp = P_S;
			dp = P_S;
		end
		if (cls == C_CVT) begin
			dp = opf[3:2];
		end
		dyadic = (cls == C_ADD) || (cls == C_SUB);
		// Source A only checked where it is used at all
		misal = bad_align(src_b, sp) || bad_align(rd, dp) || (dyadic && bad_align(src_a, sp));
		take = i_valid && ours && (st_q == S_IDLE);
		// Move data built here so the move retires in one cycle
		mv = fr_q[src_b];
		if (cls == C_NEG) begin
			mv = {~fr_q[src_b][31], fr_q[src_b][30:0]};
		end
		if (cls == C_ABS) begin
			mv = {1'b0, fr_q[src_b][30:0]};
		end
	end
	// Flags returned by the arithmetic core, masked per operation class
	always_comb begin
		fnew = i_ar_flags;
		if (cls_q == C_CVT) begin
			if (dp_q > sp_q) begin
				fnew[F_OVERFLOW] = 1'b0;
				fnew[F_UNDERFLOW] = 1'b0;
				fnew[F_INEXACT] = 1'b0;
			end
			fnew[F_BAD_OP] = snan_q;
		end
		if (cls_q == C_SQRT) begin
			fnew[F_OVERFLOW] = 1'b0;
			fnew[F_UNDERFLOW] = 1'b0;
		end
		// Result moved so its leading word sits at the top
		case (dp_q)
			P_D: wres = i_ar_result << 64;
			P_Q: wres = i_ar_result;
			default: wres = i_ar_result << 96;
		endcase
	end
	// Next state for control, outputs and register file
	always_comb begin
		fr_d = fr_q;
		st_d = st_q;
		cls_d = cls_q;
		sp_d = sp_q;
		dp_d = dp_q;
		rd_d = rd_q;
		snan_d = snan_q;
		flags_d = flags_q;
		acc_d = acc_q;
		done_d = 1'b0;
		off_d = 1'b0;
		fault_d = 1'b0;
		mis_d = 1'b0;
		unimpl_d = 1'b0;
		req_d = 1'b0;
		op_d = op_q;
		a_d = a_q;
		b_d = b_q;
		rnd_d = rnd_q;
		rdata_d = 32'h0;
		// Software port: writes first so unit writeback below wins
		if (i_reg_wr && i_reg_addr < ADDR_STATUS) begin
			fr_d[i_reg_addr[4:0]] = i_reg_wdata;
		end
		if (i_reg_wr && i_reg_addr == ADDR_STATUS) begin
			acc_d = acc_q & ~i_reg_wdata[3:0];
		end
		if (i_reg_rd) begin
			if (i_reg_addr < ADDR_STATUS) begin
				rdata_d = fr_q[i_reg_addr[4:0]];
			end else if (i_reg_addr == ADDR_STATUS) begin
				rdata_d = {27'h0, st_q == S_WAIT, acc_q};
			end
		end
		unique case (st_q)
			S_IDLE: begin
				if (take) begin
					if (!i_fpu_enable_bit || !i_fpu_present) begin
						off_d = 1'b1;
					end else if (cls == C_BAD) begin
						fault_d = 1'b1;
						unimpl_d = 1'b1;
					end else if (misal) begin
						fault_d = 1'b1;
						mis_d = 1'b1;
					end else if (cls == C_MOV || cls == C_NEG || cls == C_ABS) begin
						fr_d[rd] = mv;
						flags_d = FLAGS_RST;
						done_d = 1'b1;
					end else begin
						cls_d = cls;
						sp_d = sp;
						dp_d = dp;
						rd_d = base(rd, dp);
						b_d = rd_op(src_b, sp);
						a_d = dyadic ? rd_op(src_a, sp) : 128'h0;
						snan_d = is_snan(rd_op(src_b, sp), sp);
						op_d = opf;
						rnd_d = i_round_dir;
						req_d = 1'b1;
						st_d = S_WAIT;
					end
				end
			end
			S_WAIT: begin
				if (i_ar_done) begin
					flags_d = fnew;
					acc_d = acc_d | fnew; // Set wins over a same-cycle clear
					done_d = 1'b1;
					st_d = S_IDLE;
					if ((fnew & i_trap_mask) != 4'h0) begin
						fault_d = 1'b1; // Trapped results leave the destination untouched
					end else begin
						for (int i = 0; i < 4; i++) begin
							if (i < 1 + int'(dp_q) - int'(P_S) + ((dp_q == P_Q) ? 1 : 0)) begin
								fr_d[rd_q + 5'(i)] = wres[127 - 32 * i -: 32];
							end
						end
					end
				end
			end
		endcase
	end
	// Register stage; reset values are constants only
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			for (int i = 0; i < NREG; i++) begin
				fr_q[i] <= 32'h0;
			end
			st_q <= S_IDLE;
			cls_q <= C_BAD;
			sp_q <= P_S;
			dp_q <= P_S;
			rd_q <= 5'h0;
			snan_q <= 1'b0;
			flags_q <= FLAGS_RST;
			acc_q <= FLAGS_RST;
			done_q <= 1'b0;
			off_q <= 1'b0;
			fault_q <= 1'b0;
			mis_q <= 1'b0;
			unimpl_q <= 1'b0;
			req_q <= 1'b0;
			op_q <= 9'h0;
			a_q <= 128'h0;
			b_q <= 128'h0;
			rnd_q <= 2'h0;
			rdata_q <= 32'h0;
		end else begin
			fr_q <= fr_d;
			st_q <= st_d;
			cls_q <= cls_d;
			sp_q <= sp_d;
			dp_q <= dp_d;
			rd_q <= rd_d;
			snan_q <= snan_d;
			flags_q <= flags_d;
			acc_q <= acc_d;
			done_q <= done_d;
			off_q <= off_d;
			fault_q <= fault_d;
			mis_q <= mis_d;
			unimpl_q <= unimpl_d;
			req_q <= req_d;
			op_q <= op_d;
			a_q <= a_d;
			b_q <= b_d;
			rnd_q <= rnd_d;
			rdata_q <= rdata_d;
		end
	end
	// Outputs straight from flip-flops
	assign o_reg_rdata = rdata_q;
	assign o_busy = st_q[1]; // One-hot, so the wait bit alone is busy
	assign o_done = done_q;
	assign o_flags = flags_q;
	assign o_fpu_off_trap = off_q;
	assign o_fpu_fault_trap = fault_q;
	assign o_misaligned_fpreg_fault = mis_q;
	assign o_unimpl_fault = unimpl_q;
	assign o_ar_req = req_q;
	assign o_ar_op = op_q;
	assign o_ar_a = a_q;
	assign o_ar_b = b_q;
	assign o_ar_round = rnd_q;
	a_off_trap: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		take && !i_fpu_enable_bit |=> o_fpu_off_trap && !o_done && !o_ar_req)
		else $error("disabled unit did not trap");
	a_misalign_fault: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		take && i_fpu_enable_bit && i_fpu_present && cls != C_BAD && misal
		|=> o_fpu_fault_trap && o_misaligned_fpreg_fault && !o_busy)
		else $error("misaligned register not faulted");
	a_unimpl_code: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		take && i_fpu_enable_bit && i_fpu_present && cls == C_BAD |=> o_unimpl_fault && o_fpu_fault_trap)
		else $error("undecoded code not flagged");
	a_move_clean: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_done && !$past(o_busy) |-> o_flags == 4'h0 && !o_fpu_fault_trap)
		else $error("move raised an exception");
	a_neg_sign: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		take && i_fpu_enable_bit && i_fpu_present && cls == C_NEG && !i_reg_wr
		|=> fr_q[$past(rd)] == {~$past(fr_q[src_b][31]), $past(fr_q[src_b][30:0])})
		else $error("sign flip wrong");
	a_abs_sign: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		take && i_fpu_enable_bit && i_fpu_present && cls == C_ABS && !i_reg_wr
		|=> fr_q[$past(rd)] == {1'b0, $past(fr_q[src_b][30:0])})
		else $error("sign clear wrong");
	a_widen_clean: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		st_q == S_WAIT && i_ar_done && cls_q == C_CVT && dp_q > sp_q |=> o_flags[3:1] == 3'h0)
		else $error("widening conversion raised a flag");
	a_snan_invalid: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		st_q == S_WAIT && i_ar_done && cls_q == C_CVT |=> o_done && o_flags[F_BAD_OP] == $past(snan_q))
		else $error("conversion invalid flag wrong");
	a_req_round: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		$rose(o_busy) |-> o_ar_req && o_ar_round == $past(i_round_dir) ##1 !o_ar_req)
		else $error("request lacks rounding direction");
endmodule

// file: fcm_unit_test.sv
`timescale 1ns/1ps
module fcm_unit_test;
	import fcm_pkg::*;
	// Stimulus, observed outputs and register-file model
	logic clk = 0, srst = 1, vld = 0, en = 1, pres = 1, wr = 0, rd = 0;
	logic adone, req, busy, done, off, flt, mis, uni;
	logic [31:0] instr = 0, wd = 0, rdata, fr [32], seed = 32'h41E57D0D;
	logic [127:0] ares, a, b;
	logic [8:0] op, mf;
	logic [5:0] addr = 0;
	logic [4:0] md, ms;
	logic [3:0] mask = 0, dly = 0, cflg = 4'hF, aflg, flags, acc = 0;
	logic [1:0] rnd = 0, arnd;
	logic [17:0] ops [15];
	logic [18:0] mvs [6];
	int err_total = 0, cmp_count = 0;
	always #25 clk = ~clk;
	fcm_unit fcm_unit_i (.i_clk_sys(clk), .i_srst(srst), .i_valid(vld), .i_instr(instr), .i_fpu_enable_bit(en),
		.i_fpu_present(pres), .i_round_dir(rnd), .i_trap_mask(mask), .i_ar_done(adone), .i_ar_result(ares),
		.i_ar_flags(aflg), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_busy(busy), .o_done(done), .o_flags(flags), .o_fpu_off_trap(off), .o_fpu_fault_trap(flt),
		.o_misaligned_fpreg_fault(mis), .o_unimpl_fault(uni), .o_ar_req(req), .o_ar_op(op), .o_ar_a(a),
		.o_ar_b(b), .o_ar_round(arnd));
	fcm_core_model fcm_core_model_i (.i_clk_sys(clk), .i_req(req), .i_op(op), .i_a(a), .i_b(b), .i_dly(dly),
		.i_flg(cflg), .o_done(adone), .o_res(ares), .o_flags(aflg));
	// Reporting
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Model access: MSW sits in the lowest register
	function automatic logic [127:0] get(input int p, input int r);
		get = 0;
		for (int k = 0; k < (1 << (p - 1)); k++) get = {get[95:0], fr[r + k]};
	endfunction
	task automatic put(input int p, input int r, input logic [127:0] v);
		for (int k = (1 << (p - 1)) - 1; k >= 0; k--) begin
			fr[r + k] = v[31:0];
			v = v >> 32;
		end
	endtask
	// Register port cycles
	task automatic wreg(input logic [5:0] ad, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= ad;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [5:0] ad, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic chkregs(input int p, input int r);
		for (int k = 0; k < (1 << (p - 1)); k++) rreg(6'(r + k), fr[r + k]);
	endtask
	// Instruction offer; rounding and core delay vary per issue
	task automatic issue(input logic [4:0] d, input logic [4:0] s1, input logic [8:0] f, input logic [4:0] s2);
		seed = lfsr(seed);
		@(posedge clk);
		vld <= 1'b1;
		instr <= {FMT3, d, OP3_GROUP_ONE, s1, f, s2};
		rnd <= seed[1:0];
		dly <= seed[7:4];
		@(posedge clk);
		vld <= 1'b0;
		#1;
	endtask
	task automatic wait_done();
		for (int k = 0; k < 40; k++) begin
			if (done === 1'b1) return;
			@(posedge clk);
			#1;
		end
		chk(done, 1'b1);
		test_done();
	endtask
	// One core operation: sources at 8 and s2, destination at 16
	task automatic run(input logic [17:0] t, input logic [4:0] s2);
		logic [8:0] f;
		logic [1:0] ps, pd;
		logic two;
		logic [3:0] fe;
		logic [127:0] ea, eb;
		{f, ps, pd, two, fe} = t;
		ea = two ? get(ps, 8) : 128'h0;
		eb = get(ps, s2);
		issue(5'h10, two ? 5'h08 : 5'h1F, f, s2);
		chk(req, 1'b1);
		chk(busy, 1'b1);
		chk(op, f);
		chk(b, eb);
		chk(a, ea);
		chk(arnd, rnd);
		wait_done();
		chk(busy, 1'b0);
		chk(flags, fe);
		chk(flt, |(mask & fe));
		if (!(|(mask & fe))) put(pd, 16, f[8:2] == OPF_ADD_S[8:2] ? ea + eb : f[8:2] == OPF_SUB_S[8:2] ? ea - eb : ~eb);
		acc |= fe;
		chkregs(pd, 16);
	endtask
	// Main sequence
	initial begin
		mvs = '{{OPF_MOV, 5'h04, 5'h07}, {OPF_NEG, 5'h05, 5'h08}, {OPF_ABS, 5'h06, 5'h09},
			{OPF_NEG, 5'h14, 5'h18}, {OPF_MOV, 5'h15, 5'h19}, {OPF_ABS, 5'h1C, 5'h1C}};
		ops = '{{OPF_S2D, P_S, P_D, 1'b0, 4'h0}, {OPF_S2Q, P_S, P_Q, 1'b0, 4'h0}, {OPF_D2Q, P_D, P_Q, 1'b0, 4'h0},
			{OPF_D2S, P_D, P_S, 1'b0, 4'hE}, {OPF_Q2S, P_Q, P_S, 1'b0, 4'hE}, {OPF_Q2D, P_Q, P_D, 1'b0, 4'hE},
			{OPF_SQRT_S, P_S, P_S, 1'b0, 4'h3}, {OPF_SQRT_D, P_D, P_D, 1'b0, 4'h3}, {OPF_SQRT_Q, P_Q, P_Q, 1'b0, 4'h3},
			{OPF_ADD_S, P_S, P_S, 1'b1, 4'hF}, {OPF_ADD_D, P_D, P_D, 1'b1, 4'hF}, {OPF_ADD_Q, P_Q, P_Q, 1'b1, 4'hF},
			{OPF_SUB_S, P_S, P_S, 1'b1, 4'hF}, {OPF_SUB_D, P_D, P_D, 1'b1, 4'hF}, {OPF_SUB_Q, P_Q, P_Q, 1'b1, 4'hF}};
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		// Fill the file; sources 8 and 12 kept finite so among conversions only the sNaN case sets invalid
		for (int r = 0; r < NREG; r++) begin
			seed = lfsr(seed);
			fr[r] = (r == 8 || r == 12) ? 32'h3F800000 : seed;
			wreg(6'(r), fr[r]);
		end
		wreg(6'h3F, 32'hFFFFFFFF);
		rreg(6'h21, 32'h0);
		// Copy and sign moves, including the absolute value with one register as both source and destination
		foreach (mvs[i]) begin
			{mf, md, ms} = mvs[i];
			issue(md, 5'h1F, mf, ms);
			chk({done, flags}, 5'h10);
			fr[md] = fr[ms] ^ (mf == OPF_NEG ? 32'h80000000 : 32'h0);
			if (mf == OPF_ABS) fr[md][31] = 1'b0;
			rreg({1'b0, md}, fr[md]);
		end
		// Trap order: disabled, absent, unimplemented, misaligned
		@(posedge clk);
		en <= 1'b0;
		issue(5'h00, 5'h00, OPF_MOV, 5'h01);
		chk(off, 1'b1);
		@(posedge clk);
		en <= 1'b1;
		pres <= 1'b0;
		issue(5'h00, 5'h00, OPF_ADD_S, 5'h01);
		chk(off, 1'b1);
		@(posedge clk);
		pres <= 1'b1;
		issue(5'h00, 5'h00, 9'h1FF, 5'h01);
		chk({flt, uni, mis}, 3'b110);
		issue(5'h02, 5'h00, OPF_D2S, 5'h03);
		chk({flt, uni, mis}, 3'b101);
		issue(5'h00, 5'h00, OPF_Q2D, 5'h06);
		chk({flt, uni, mis}, 3'b101);
		issue(5'h02, 5'h00, OPF_D2Q, 5'h00);
		chk({flt, uni, mis}, 3'b101);
		issue(5'h04, 5'h05, OPF_ADD_D, 5'h00);
		chk({flt, uni, mis}, 3'b101);
		foreach (ops[i]) run(ops[i], 5'h0C);
		fr[20] = 32'h7FA00000;
		wreg(6'h14, fr[20]);
		run({OPF_S2D, P_S, P_D, 1'b0, 4'h1}, 5'h14);
		// Accrued flags, then write-one-to-clear
		rreg(ADDR_STATUS, {27'h0, 1'b0, acc});
		wreg(ADDR_STATUS, 32'h0000000F);
		rreg(ADDR_STATUS, 32'h0);
		// Enabled flag turns the retire into a fault, destination kept
		@(posedge clk);
		mask <= 4'h8;
		run({OPF_SUB_S, P_S, P_S, 1'b1, 4'hF}, 5'h0C);
		test_done();
	end
endmodule
